// ===== logic/ebra_top.sv
`timescale 1ns/10ps
// Behaviour
// - READY high at the sampling point adds a wait state and samples again.
// - READY low at the sampling point ends the running bus cycle.
// - Programmed memory-cycle wait states stretch the cycle before READY sampling.
// - The command-delay setting decides when the strobe goes active.
// - Multiplexed mode adds a turnaround wait, optionally a tristate wait.
// - Delay after cycle is two bus clocks muxed with tristate, one with either alone, zero with neither.
// - A running cycle completes before the bus is granted away.
// - After release the chip selects float and are pulled high.
// - Regaining starts only when the release request goes high.
// - Read data is captured on the edge that raises the read strobe.
module ebra_top #(
  parameter int ADDR_WIDTH = 24,
  parameter int DATA_WIDTH = 16
) (
  input  wire logic                  clk_i,                   // System clock.
  input  wire logic                  rst_i,                   // Sync reset, high.
  input  wire logic                  wb_cyc_i,                // Wishbone cycle.
  input  wire logic                  wb_stb_i,                // Wishbone strobe.
  input  wire logic                  wb_we_i,                 // Wishbone write.
  input  wire logic [7:0]            wb_adr_i,                // Byte address.
  input  wire logic [3:0]            wb_sel_i,                // Byte enables.
  input  wire logic [31:0]           wb_dat_i,                // Write data.
  output logic      [31:0]           wb_dat_o,                // Read data.
  output logic                       wb_ack_o,                // Acknowledge.
  input  wire logic                  ready_n_i,               // READY pin, low ends.
  input  wire logic                  bus_release_request_n_i, // Hold pin, low.
  input  wire logic [DATA_WIDTH-1:0] data_i,                  // Data bus in.
  output logic      [DATA_WIDTH-1:0] data_o,                  // Data bus out.
  output logic                       data_oe_o,               // Data bus drive.
  output logic      [ADDR_WIDTH-1:0] addr_o,                  // Address out.
  output logic                       bus_oe_o,                // Addr, strobes drive.
  output logic                       rd_n_o,                  // Read strobe.
  output logic                       wr_n_o,                  // Write strobe.
  output logic                       cs_n_o,                  // Chip select.
  output logic                       cs_oe_o,                 // Chip select drive.
  output logic                       bus_clock_output_o,      // Bus clock out.
  output logic                       bus_grant_ack_n_o,       // Grant, low.
  output logic                       bus_regain_request_n_o   // Regain, low.
);

  // ==========================================================================
  // Elaboration checks.
  if (ADDR_WIDTH < 1 || ADDR_WIDTH > 24) begin : g_chk_addr
    $error("ADDR_WIDTH must lie between 1 and 24");
  end
  if (DATA_WIDTH != 8 && DATA_WIDTH != 16) begin : g_chk_data
    $error("DATA_WIDTH must be 8 or 16");
  end

  // ==========================================================================
  // Pin synchronisers.
  localparam int SW = DATA_WIDTH + 2;
  localparam logic [SW-1:0] SYNC_RESET = {2'b11, {DATA_WIDTH{1'b0}}};

  logic [SW-1:0]         sync_q;
  logic                  ready_s_n;
  logic                  hold_s_n;
  logic [DATA_WIDTH-1:0] data_s;

  ebra_sync #(
    .WIDTH       (SW),
    .RESET_VALUE (SYNC_RESET)
  ) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({ready_n_i, bus_release_request_n_i, data_i}),
    .q_o   (sync_q)
  );

  assign ready_s_n = sync_q[SW-1];
  assign hold_s_n  = sync_q[SW-2];
  assign data_s    = sync_q[DATA_WIDTH-1:0];

  // ==========================================================================
  // Shared declarations.
  ebra_pkg::ebra_state_type state, next_state;

  logic [ebra_pkg::CFG_WIDTH-1:0] cfg, next_cfg;
  logic [ADDR_WIDTH-1:0]          addr_reg, next_addr_reg;
  logic [DATA_WIDTH-1:0]          wdata_reg, next_wdata_reg;
  logic [DATA_WIDTH-1:0]          rdata_reg, next_rdata_reg;
  logic                           write_flag, next_write_flag;
  logic                           pending, next_pending;
  logic                           done, next_done;
  logic [31:0]                    next_wb_dat;
  logic                           next_wb_ack;
  logic                           cycle_taken;
  logic                           cycle_end;
  logic                           in_cycle;
  logic                           tick;
  logic [ebra_pkg::CFG_WS_WIDTH-1:0] ws;
  logic [3:0]                     rec_waits;

  assign ws = cfg[ebra_pkg::CFG_WS_LSB +: ebra_pkg::CFG_WS_WIDTH];
  assign rec_waits = (cfg[ebra_pkg::CFG_MUX_BIT] ? ebra_pkg::MUX_TURN_WAITS : 4'h0)
                   + (cfg[ebra_pkg::CFG_TRI_BIT] ? ebra_pkg::TRISTATE_WAITS : 4'h0);
  assign in_cycle = (state == ebra_pkg::ST_ADDR) || (state == ebra_pkg::ST_DELAY) ||
                    (state == ebra_pkg::ST_WAITMC) || (state == ebra_pkg::ST_STROBE) ||
                    (state == ebra_pkg::ST_RECOVER);
  // The next clock edge is a rising edge of the bus clock output.
  assign tick = ~bus_clock_output_o;

  function automatic logic [31:0] ebra_merge(input logic [31:0] old,
                                             input logic [31:0] din,
                                             input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = din[8*b +: 8];
      end
    end
    return r;
  endfunction

  // ==========================================================================
  // Wishbone register file.
  logic [31:0] rd_value;
  logic [31:0] merged;
  logic        wb_req;

  always_comb begin
    wb_req          = wb_cyc_i & wb_stb_i;
    next_cfg        = cfg;
    next_addr_reg   = addr_reg;
    next_wdata_reg  = wdata_reg;
    next_write_flag = write_flag;
    next_pending    = pending;
    next_done       = done;
    next_wb_ack     = wb_req & ~wb_ack_o;
    rd_value        = 32'h0000_0000;
    merged          = 32'h0000_0000;
    case (wb_adr_i)
      ebra_pkg::REG_CONFIG: rd_value = 32'(cfg);
      ebra_pkg::REG_ADDR:   rd_value = 32'(addr_reg);
      ebra_pkg::REG_WDATA:  rd_value = 32'(wdata_reg);
      ebra_pkg::REG_RDATA:  rd_value = 32'(rdata_reg);
      ebra_pkg::REG_STATUS: begin
        rd_value[ebra_pkg::STAT_BUSY_BIT]   = pending | in_cycle;
        rd_value[ebra_pkg::STAT_HELD_BIT]   = (state == ebra_pkg::ST_HELD);
        rd_value[ebra_pkg::STAT_REGAIN_BIT] = ~bus_regain_request_n_o;
        rd_value[ebra_pkg::STAT_DONE_BIT]   = done;
      end
      default: rd_value = 32'h0000_0000;
    endcase
    next_wb_dat = (wb_req & ~wb_ack_o) ? rd_value : wb_dat_o;
    if (wb_req & wb_we_i & wb_ack_o) begin
      case (wb_adr_i)
        ebra_pkg::REG_CONFIG: begin
          merged   = ebra_merge(32'(cfg), wb_dat_i, wb_sel_i);
          next_cfg = merged[ebra_pkg::CFG_WIDTH-1:0];
        end
        ebra_pkg::REG_ADDR: begin
          merged        = ebra_merge(32'(addr_reg), wb_dat_i, wb_sel_i);
          next_addr_reg = merged[ADDR_WIDTH-1:0];
        end
        ebra_pkg::REG_WDATA: begin
          merged         = ebra_merge(32'(wdata_reg), wb_dat_i, wb_sel_i);
          next_wdata_reg = merged[DATA_WIDTH-1:0];
        end
        ebra_pkg::REG_CMD: begin
          if (wb_sel_i[0]) begin
            next_done = 1'b0;
            if (wb_dat_i[ebra_pkg::CMD_START_BIT] && !(pending || in_cycle)) begin
              next_pending    = 1'b1;
              next_write_flag = wb_dat_i[ebra_pkg::CMD_WRITE_BIT];
            end
          end
        end
        default: next_cfg = cfg;
      endcase
    end
    if (cycle_taken) begin
      next_pending = 1'b0;
    end
    // Completion set overrides a software clear in the same cycle.
    if (cycle_end) begin
      next_done = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg        <= ebra_pkg::CFG_RESET;
      addr_reg   <= '0;
      wdata_reg  <= '0;
      write_flag <= 1'b0;
      pending    <= 1'b0;
      done       <= 1'b0;
      wb_ack_o   <= 1'b0;
      wb_dat_o   <= 32'h0000_0000;
    end else begin
      cfg        <= next_cfg;
      addr_reg   <= next_addr_reg;
      wdata_reg  <= next_wdata_reg;
      write_flag <= next_write_flag;
      pending    <= next_pending;
      done       <= next_done;
      wb_ack_o   <= next_wb_ack;
      wb_dat_o   <= next_wb_dat;
    end
  end

  // ==========================================================================
  // Bus sequencer and arbitration.
  logic [3:0]            cnt, next_cnt;
  logic [DATA_WIDTH-1:0] next_data_o;
  logic [ADDR_WIDTH-1:0] next_addr_o;
  logic next_data_oe, next_bus_oe, next_rd_n, next_wr_n, next_cs_n, next_cs_oe;
  logic next_bco, next_grant_n, next_regain_n, go_strobe;

  always_comb begin
    next_state     = state;
    next_cnt       = cnt;
    next_rdata_reg = rdata_reg;
    next_data_o    = data_o;
    next_addr_o    = addr_o;
    next_data_oe   = data_oe_o;
    next_bus_oe    = bus_oe_o;
    next_rd_n      = rd_n_o;
    next_wr_n      = wr_n_o;
    next_cs_n      = cs_n_o;
    next_cs_oe     = cs_oe_o;
    next_bco       = ~bus_clock_output_o;
    next_grant_n   = bus_grant_ack_n_o;
    next_regain_n  = bus_regain_request_n_o;
    cycle_taken    = 1'b0;
    cycle_end      = 1'b0;
    go_strobe      = 1'b0;
    if (tick) begin
      case (state)
        ebra_pkg::ST_IDLE: begin
          if (!hold_s_n) begin
            next_state   = ebra_pkg::ST_FLOAT;
            next_bus_oe  = 1'b0;
            next_cs_oe   = 1'b0;
            next_cs_n    = 1'b1;
            next_data_oe = 1'b0;
          end else if (pending) begin
            next_state   = ebra_pkg::ST_ADDR;
            next_addr_o  = addr_reg;
            next_cs_n    = 1'b0;
            next_data_o  = wdata_reg;
            next_data_oe = write_flag;
            cycle_taken  = 1'b1;
          end
        end
        ebra_pkg::ST_ADDR: begin
          if (cfg[ebra_pkg::CFG_RWDLY_BIT]) begin
            next_state = ebra_pkg::ST_DELAY;
          end else begin
            go_strobe = 1'b1;
          end
        end
        ebra_pkg::ST_DELAY: go_strobe = 1'b1;
        ebra_pkg::ST_WAITMC: begin
          if (cnt == 4'h1) begin
            next_state = ebra_pkg::ST_STROBE;
          end else begin
            next_cnt = cnt - 4'h1;
          end
        end
        ebra_pkg::ST_STROBE: begin
          if (cfg[ebra_pkg::CFG_RDYEN_BIT] && ready_s_n) begin
            next_state = ebra_pkg::ST_STROBE;
          end else begin
            next_rd_n    = 1'b1;
            next_wr_n    = 1'b1;
            next_cs_n    = 1'b1;
            next_data_oe = 1'b0;
            cycle_end    = 1'b1;
            if (!write_flag) begin
              next_rdata_reg = data_s;
            end
            if (rec_waits != 4'h0) begin
              next_state = ebra_pkg::ST_RECOVER;
              next_cnt   = rec_waits;
            end else begin
              next_state = ebra_pkg::ST_IDLE;
            end
          end
        end
        ebra_pkg::ST_RECOVER: begin
          if (cnt == 4'h1) begin
            next_state = ebra_pkg::ST_IDLE;
          end else begin
            next_cnt = cnt - 4'h1;
          end
        end
        ebra_pkg::ST_FLOAT: begin
          next_state   = ebra_pkg::ST_HELD;
          next_grant_n = 1'b0;
        end
        ebra_pkg::ST_HELD: begin
          // Release may end with or without a pending request of our own.
          if (hold_s_n) begin
            next_state    = ebra_pkg::ST_REGAIN;
            next_grant_n  = 1'b1;
            next_regain_n = 1'b1;
          end else begin
            next_regain_n = ~pending;
          end
        end
        ebra_pkg::ST_REGAIN: begin
          next_state  = ebra_pkg::ST_IDLE;
          next_bus_oe = 1'b1;
          next_cs_oe  = 1'b1;
        end
        default: next_state = ebra_pkg::ST_IDLE;
      endcase
      if (go_strobe) begin
        next_rd_n = write_flag;
        next_wr_n = ~write_flag;
        if (ws != '0) begin
          next_state = ebra_pkg::ST_WAITMC;
          next_cnt   = 4'(ws);
        end else begin
          next_state = ebra_pkg::ST_STROBE;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state                  <= ebra_pkg::ST_IDLE;
      cnt                    <= 4'h0;
      rdata_reg              <= '0;
      data_o                 <= '0;
      addr_o                 <= '0;
      data_oe_o              <= 1'b0;
      bus_oe_o               <= 1'b1;
      rd_n_o                 <= 1'b1;
      wr_n_o                 <= 1'b1;
      cs_n_o                 <= 1'b1;
      cs_oe_o                <= 1'b1;
      bus_clock_output_o     <= 1'b0;
      bus_grant_ack_n_o      <= 1'b1;
      bus_regain_request_n_o <= 1'b1;
    end else begin
      state                  <= next_state;
      cnt                    <= next_cnt;
      rdata_reg              <= next_rdata_reg;
      data_o                 <= next_data_o;
      addr_o                 <= next_addr_o;
      data_oe_o              <= next_data_oe;
      bus_oe_o               <= next_bus_oe;
      rd_n_o                 <= next_rd_n;
      wr_n_o                 <= next_wr_n;
      cs_n_o                 <= next_cs_n;
      cs_oe_o                <= next_cs_oe;
      bus_clock_output_o     <= next_bco;
      bus_grant_ack_n_o      <= next_grant_n;
      bus_regain_request_n_o <= next_regain_n;
    end
  end

  // ==========================================================================
  // Assertions.
  AST_READY_WAIT: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == ebra_pkg::ST_STROBE && tick && cfg[ebra_pkg::CFG_RDYEN_BIT] && ready_s_n)
    |=> (state == ebra_pkg::ST_STROBE) && !(rd_n_o && wr_n_o))
    else $error("READY high did not hold the strobe");

  AST_READY_END: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == ebra_pkg::ST_STROBE && tick && !ready_s_n)
    |=> (state != ebra_pkg::ST_STROBE) && rd_n_o && wr_n_o && cs_n_o)
    else $error("READY low did not end the cycle");

  AST_MC_WAIT: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(state == ebra_pkg::ST_STROBE)
    |-> (ws == '0) || ($past(state) == ebra_pkg::ST_WAITMC))
    else $error("Sampling point reached without programmed wait states");

  AST_CMD_DELAY: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == ebra_pkg::ST_ADDR && tick && cfg[ebra_pkg::CFG_RWDLY_BIT])
    |=> (state == ebra_pkg::ST_DELAY) && rd_n_o && wr_n_o ##2 !(rd_n_o && wr_n_o))
    else $error("Command delay not applied to the strobe");

  AST_RECOVER_TWO: assert property (@(posedge clk_i) disable iff (rst_i)
    ($fell(state == ebra_pkg::ST_STROBE) && cfg[ebra_pkg::CFG_MUX_BIT] &&
     cfg[ebra_pkg::CFG_TRI_BIT])
    |-> (state == ebra_pkg::ST_RECOVER)[*4] ##1 (state == ebra_pkg::ST_IDLE))
    else $error("Muxed tristate recovery is not two bus clocks");

  AST_RECOVER_NONE: assert property (@(posedge clk_i) disable iff (rst_i)
    ($fell(state == ebra_pkg::ST_STROBE) && !cfg[ebra_pkg::CFG_MUX_BIT] &&
     !cfg[ebra_pkg::CFG_TRI_BIT])
    |-> (state == ebra_pkg::ST_IDLE))
    else $error("Demultiplexed cycle added a recovery delay");

  AST_HOLD_AFTER_CYCLE: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(state == ebra_pkg::ST_FLOAT) |-> $past(state) == ebra_pkg::ST_IDLE && cs_n_o)
    else $error("Bus released during a running cycle");

  AST_GRANT_FLOATED: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(bus_grant_ack_n_o) |-> !cs_oe_o && !bus_oe_o && !data_oe_o && !$past(cs_oe_o))
    else $error("Grant given while outputs still driven");

  AST_DRIVE_AFTER_UNGRANT: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(cs_oe_o) |-> bus_grant_ack_n_o && $past(bus_grant_ack_n_o, 2))
    else $error("Chip selects driven before grant was withdrawn");

  AST_REGAIN_ON_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == ebra_pkg::ST_HELD && tick)
    |=> (bus_grant_ack_n_o == $past(hold_s_n)) &&
        ($past(hold_s_n) ? state == ebra_pkg::ST_REGAIN : state == ebra_pkg::ST_HELD))
    else $error("Regain did not follow the release request");

  AST_EDGE_ALIGNED: assert property (@(posedge clk_i) disable iff (rst_i)
    ($changed(bus_grant_ack_n_o) || $changed(bus_regain_request_n_o))
    |-> $rose(bus_clock_output_o))
    else $error("Arbitration output changed off a bus clock edge");

  AST_READ_CAPTURE: assert property (@(posedge clk_i) disable iff (rst_i)
    ($rose(rd_n_o) && !write_flag) |-> rdata_reg == $past(data_s))
    else $error("Read data not captured on the strobe edge");

endmodule // ebra_top

// ===== logic/ebra_pkg.sv
package ebra_pkg;

  // ==========================================================================
  // Register map, byte addresses on the Wishbone side.
  localparam logic [7:0] REG_CONFIG = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_WDATA  = 8'h08;
  localparam logic [7:0] REG_CMD    = 8'h0C;
  localparam logic [7:0] REG_RDATA  = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;

  // ==========================================================================
  // Configuration field layout and reset value.
  localparam int         CFG_WIDTH     = 8;
  localparam int         CFG_WS_LSB    = 0;
  localparam int         CFG_WS_WIDTH  = 4;
  localparam int         CFG_RWDLY_BIT = 4;
  localparam int         CFG_MUX_BIT   = 5;
  localparam int         CFG_TRI_BIT   = 6;
  localparam int         CFG_RDYEN_BIT = 7;
  localparam logic [7:0] CFG_RESET     = 8'h80;

  // ==========================================================================
  // Command and status bits.
  localparam int CMD_START_BIT  = 0;
  localparam int CMD_WRITE_BIT  = 1;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_HELD_BIT  = 1;
  localparam int STAT_REGAIN_BIT = 2;
  localparam int STAT_DONE_BIT  = 3;

  // ==========================================================================
  // Bus clock periods added after a cycle by each recovery wait state.
  localparam logic [3:0] MUX_TURN_WAITS = 4'h1;
  localparam logic [3:0] TRISTATE_WAITS = 4'h1;

  // ==========================================================================
  // Bus sequencer states, Gray coded in the order they are listed.
  typedef enum logic [3:0] {
    ST_IDLE    = 4'h0,
    ST_ADDR    = 4'h1,
    ST_DELAY   = 4'h3,
    ST_WAITMC  = 4'h2,
    ST_STROBE  = 4'h6,
    ST_RECOVER = 4'h7,
    ST_FLOAT   = 4'h5,
    ST_HELD    = 4'h4,
    ST_REGAIN  = 4'hC
  } ebra_state_type;

endpackage

// ===== logic/ebra_sync.sv
`timescale 1ns/10ps
module ebra_sync #(
  parameter int               WIDTH       = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input  wire logic             clk_i,  // System clock.
  input  wire logic             rst_i,  // Synchronous reset, active high.
  input  wire logic [WIDTH-1:0] d_i,    // Asynchronous inputs.
  output logic      [WIDTH-1:0] q_o     // Synchronised outputs.
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= RESET_VALUE;
      q_o  <= RESET_VALUE;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end

endmodule // ebra_sync

// ===== testbench/ebra_ext_mem.sv
`timescale 1ns/10ps
// ==========================================================================
// External memory that answers each strobe with READY after a set delay.
module ebra_ext_mem (
  input  wire logic        clk_i,     // System clock.
  input  wire logic [23:0] addr_i,    // Address from the device.
  input  wire logic        rd_n_i,    // Read strobe.
  input  wire logic        wr_n_i,    // Write strobe.
  input  wire logic [15:0] data_i,    // Data from the device.
  input  wire logic [3:0]  delay_i,   // Clocks before READY goes low.
  output logic             ready_n_o, // READY pin.
  output logic      [15:0] data_o     // Data toward the device.
);
  logic [15:0] mem [16];
  logic [3:0]  cnt = 4'h0;
  logic [15:0] idle = 16'h5A5A;
  initial ready_n_o = 1'b1;
  // Undriven data lines show a pattern that flips every clock.
  assign data_o = !rd_n_i ? mem[addr_i[3:0]] : idle;
  always @(posedge clk_i) begin
    idle <= ~idle;
    if (rd_n_i && wr_n_i) begin
      ready_n_o <= 1'b1;
      cnt <= 4'h0;
    end else begin
      cnt <= cnt + 4'h1;
      ready_n_o <= (cnt < delay_i);
      if (!wr_n_i) mem[addr_i[3:0]] <= data_i;
    end
  end
endmodule // ebra_ext_mem

// ===== testbench/tb_ext_bus_ready_and_hold_arbitration.sv
`timescale 1ns/10ps
module tb_ext_bus_ready_and_hold_arbitration;
  logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, hold_n = 1'b1;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000, dat_o, got, seed = 32'h0000_630b;
  logic        ack, data_oe, bus_oe, rd_n, wr_n, cs_n, cs_oe, gnt_n, rgn_n, rdy_n, bco;
  logic [15:0] d_out, d_in, val;
  logic [23:0] addr;
  logic [3:0]  dly = 4'h0;
  logic [7:0]  cfgs [5] = '{8'h80, 8'h93, 8'hE1, 8'hA0, 8'h41};
  logic [32:0] q [$];
  logic [32:0] e;
  int          miscompares = 0, n_tests = 0;
  wire         cs_w = cs_oe ? cs_n : 1'b1;
  ebra_top dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .ready_n_i(rdy_n), .bus_release_request_n_i(hold_n), .data_i(d_in), .data_o(d_out),
    .data_oe_o(data_oe), .addr_o(addr), .bus_oe_o(bus_oe), .rd_n_o(rd_n), .wr_n_o(wr_n),
    .cs_n_o(cs_n), .cs_oe_o(cs_oe), .bus_clock_output_o(bco), .bus_grant_ack_n_o(gnt_n),
    .bus_regain_request_n_o(rgn_n));
  ebra_ext_mem mem (.clk_i(clk), .addr_i(addr), .rd_n_i(rd_n), .wr_n_i(wr_n),
    .data_i(d_out), .delay_i(dly), .ready_n_o(rdy_n), .data_o(d_in));
  initial begin
    forever #4 clk = ~clk;
  end
  // ========================================================================
  // Helpers.
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic conclude;
    if (miscompares == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] exp, input logic [31:0] act);
    n_tests++;
    if (act !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, exp, act);
    end
  endtask
  task automatic give_up;
    miscompares++;
    conclude();
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic chk, input logic [31:0] exp);
    int i;
    if (!w) q.push_back({chk, exp});
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    for (i = 0; i < 50 && ack !== 1'b1; i++) @(posedge clk);
    got = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (i == 50) give_up();
  endtask
  task automatic wait_done;
    int i;
    got = 32'h0000_0000;
    for (i = 0; i < 100 && got[ebra_pkg::STAT_DONE_BIT] !== 1'b1; i++) begin
      wb(1'b0, ebra_pkg::REG_STATUS, 32'h0000_0000, 1'b0, 32'h0000_0000);
    end
    if (got[ebra_pkg::STAT_DONE_BIT] !== 1'b1) give_up();
  endtask
  task automatic wait_grant(input logic want);
    int i;
    for (i = 0; i < 100 && gnt_n !== want; i++) @(posedge clk);
    if (gnt_n !== want) give_up();
  endtask
  // ========================================================================
  // Result watcher.
  always @(posedge clk) begin
    if (ack === 1'b1 && !we && q.size() > 0) begin
      e = q.pop_front();
      if (e[32]) cmp(e[31:0], dat_o);
    end
  end
  // ========================================================================
  // Main sequence.
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    wb(1'b0, ebra_pkg::REG_CONFIG, 32'h0000_0000, 1'b1, {24'h00_0000, ebra_pkg::CFG_RESET});
    wb(1'b0, 8'hFC, 32'h0000_0000, 1'b1, 32'h0000_0000);
    wb(1'b0, ebra_pkg::REG_STATUS, 32'h0000_0000, 1'b1, 32'h0000_0000);
    foreach (cfgs[k]) begin
      seed = lfsr(seed);
      dly <= {1'b0, seed[18:16]};
      val = seed[15:0];
      wb(1'b1, ebra_pkg::REG_CONFIG, {24'h00_0000, cfgs[k]}, 1'b0, 32'h0000_0000);
      wb(1'b0, ebra_pkg::REG_CONFIG, 32'h0000_0000, 1'b1, {24'h00_0000, cfgs[k]});
      wb(1'b1, ebra_pkg::REG_ADDR, {28'h000_0000, seed[23:20]}, 1'b0, 32'h0000_0000);
      wb(1'b1, ebra_pkg::REG_WDATA, {16'h0000, val}, 1'b0, 32'h0000_0000);
      wb(1'b1, ebra_pkg::REG_CMD, 32'h0000_0003, 1'b0, 32'h0000_0000);
      wait_done();
      wb(1'b1, ebra_pkg::REG_CMD, 32'h0000_0001, 1'b0, 32'h0000_0000);
      wait_done();
      wb(1'b0, ebra_pkg::REG_RDATA, 32'h0000_0000, 1'b1, {16'h0000, val});
    end
    hold_n <= 1'b0;
    wait_grant(1'b0);
    cmp({30'h0000_0000, cs_oe, cs_w}, 32'h0000_0001);
    cmp({30'h0000_0000, bus_oe, data_oe}, 32'h0000_0000);
    wb(1'b1, ebra_pkg::REG_CMD, 32'h0000_0001, 1'b0, 32'h0000_0000);
    repeat (6) @(posedge clk);
    cmp({31'h0000_0000, rd_n}, 32'h0000_0001);
    cmp({31'h0000_0000, rgn_n}, 32'h0000_0000);
    hold_n <= 1'b1;
    wait_grant(1'b1);
    wait_done();
    wb(1'b0, ebra_pkg::REG_RDATA, 32'h0000_0000, 1'b1, {16'h0000, val});
    cmp({8'h00, addr}, {28'h000_0000, seed[23:20]});
    hold_n <= 1'b0;
    wait_grant(1'b0);
    cmp({31'h0000_0000, rgn_n}, 32'h0000_0001);
    wb(1'b0, ebra_pkg::REG_STATUS, 32'h0000_0000, 1'b1, 32'h0000_000A);
    hold_n <= 1'b1;
    wait_grant(1'b1);
    repeat (4) @(posedge clk);
    cmp({31'h0000_0000, bus_oe}, 32'h0000_0001);
    val[0] = bco;
    @(posedge clk);
    cmp({31'h0000_0000, bco}, {31'h0000_0000, ~val[0]});
    conclude();
  end
endmodule // tb_ext_bus_ready_and_hold_arbitration
